//--- core/rmcr_pkg.sv
package rmcr_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_DRV_CHG = 6'h1e;
  localparam logic [5:0] IDX_FLP_RATE = 6'h1f;
  localparam logic [5:0] IDX_SER1_FCR = 6'h20;
  localparam logic [5:0] IDX_SER2_FCR = 6'h21;
  localparam logic [5:0] IDX_KILL = 6'h22;
  localparam logic [5:0] IDX_PIN_CFG = 6'h23;

  // Reset values.
  localparam logic [1:0] RST_DRV_CHG = 2'h1;
  localparam logic [7:0] RST_SHADOW = 8'h00;
  localparam logic [7:0] RST_KILL = 8'h00;
  localparam logic [7:0] RST_PIN_CFG = 8'h01;

  // Writable bits of the kill switch; bits 2:1 are reserved.
  localparam logic [7:0] KILL_MASK = 8'hf9;
  // Kill switch field positions.
  localparam int KILL_WP = 0;
  localparam int KILL_FLOPPY = 3;
  localparam int KILL_MIDI = 4;
  localparam int KILL_SER2 = 5;
  localparam int KILL_SER1 = 6;
  localparam int KILL_PAR = 7;

  // Implemented bits of the pin configuration; bits 6:3 are reserved.
  localparam logic [7:0] PIN_CFG_MASK = 8'h87;
  // Pin configuration field positions.
  localparam int PIN_DIR_IN = 0;
  localparam int PIN_INVERT = 1;
  localparam int PIN_ALT = 2;
  localparam int PIN_OPEN_DRAIN = 7;

  // Lock field value that arms the write lock.
  localparam logic [1:0] LOCK_ARMED = 2'b01;

  // Number of pins that pass the input synchroniser.
  localparam int NPIN = 7;
  // Positions inside the synchronised pin vector.
  localparam int P_STEP = 0;
  localparam int P_DS0 = 1;
  localparam int P_DS1 = 2;
  localparam int P_DISK_CHANGED_STATUS = 3;
  localparam int P_WRTPRT = 4;
  localparam int P_LOCK = 5;
  localparam int P_STICK = 6;
  // Idle levels of the pins: active-low lines rest high.
  localparam logic [6:0] PIN_IDLE = 7'h1f;

endpackage : rmcr_pkg

//--- core/rmcr_top.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

module rmcr_top (
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave, byte address.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Floppy interface pins, all active low.
  input wire logic head_step_pulse_n,
  input wire logic drive_select_zero_n,
  input wire logic drive_select_one_n,
  input wire logic disk_changed_pin_n,
  input wire logic write_protect_line_n,
  // Lock pin and its alternate-function field.
  input wire logic lock_control_pin,
  input wire logic [1:0] lock_field,
  // Forced write-protect configuration bit.
  input wire logic force_write_protect,
  // Shadow capture strobes from the write-only registers.
  input wire logic rate_wr,
  input wire logic [7:0] rate_wdata,
  input wire logic ser1_fcr_wr,
  input wire logic [7:0] ser1_fcr_wdata,
  input wire logic ser2_fcr_wr,
  input wire logic [7:0] ser2_fcr_wdata,
  // Activate bits of the functions.
  input wire logic floppy_activate,
  input wire logic midi_activate,
  input wire logic serial2_activate,
  input wire logic serial1_activate,
  input wire logic parallel_activate,
  // Effective enables after the kill switch.
  output logic floppy_enable,
  output logic midi_enable,
  output logic serial2_enable,
  output logic serial1_enable,
  output logic parallel_enable,
  // Floppy core side.
  output logic disk_changed_status,
  output logic write_protect_core_n,
  // General-purpose pin shared with the joystick button.
  input wire logic stick1_button1_pin_i,
  output logic stick1_button1_pin_o,
  output logic stick1_button1_pin_oe,
  input wire logic gpio_out_value,
  output logic gpio_in_value,
  output logic stick1_button1
);

  // Register index taken from the word part of the byte address.
  logic [5:0] idx;
  // Low byte lane enable of a write.
  logic lane0;
  // Request is in its answer cycle.
  logic acc_go;
  // Write that takes effect on this edge.
  logic wr_go;
  // Lock condition on the kill switch.
  logic kill_locked;

  // Synchroniser stages; s1 feeds s2 only.
  logic [rmcr_pkg::NPIN-1:0] pin_s1_q;
  logic [rmcr_pkg::NPIN-1:0] pin_s2_q;
  logic [rmcr_pkg::NPIN-1:0] pin_s3_q;
  // Filtered pin levels.
  logic [rmcr_pkg::NPIN-1:0] pin_f_q;
  // Raw pin vector.
  logic [rmcr_pkg::NPIN-1:0] pin_raw;

  // Forced disk-change flags.
  logic [1:0] drv_chg_q;
  logic [1:0] drv_chg_d;
  // Shadows.
  logic [7:0] rate_q;
  logic [7:0] ser1_q;
  logic [7:0] ser2_q;
  // Kill switch and pin configuration.
  logic [7:0] kill_q;
  logic [7:0] pin_cfg_q;
  // Read mux value.
  logic [7:0] rd_byte;
  // Pin drive value after polarity.
  logic pin_val;

  // Masks a byte lane of write data to a register's writable bits.
  function automatic logic [7:0] wr_mask(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    wr_mask = data & mask;
  endfunction : wr_mask

  // Decoded request terms.
  assign idx = avs_address[7:2];
  assign lane0 = avs_byteenable[0];
  // The answer cycle is the one with waitrequest low.
  assign acc_go = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_go = acc_go & avs_write & lane0;

  // All pins in one vector so they share one synchroniser.
  assign pin_raw = {
    stick1_button1_pin_i,
    lock_control_pin,
    write_protect_line_n,
    disk_changed_pin_n,
    drive_select_one_n,
    drive_select_zero_n,
    head_step_pulse_n
  };

  // Three-stage synchroniser for the asynchronous pins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= rmcr_pkg::PIN_IDLE;
      pin_s2_q <= rmcr_pkg::PIN_IDLE;
      pin_s3_q <= rmcr_pkg::PIN_IDLE;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // A level counts only once the second and third stages agree.
  // This rejects a single-cycle glitch at the cost of one cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_f_q <= rmcr_pkg::PIN_IDLE;
    end else begin
      pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // Waitrequest rests high and drops for one cycle per request.
  // The single wait state gives the read mux a full cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read mux; unmapped indices and reserved bits return zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      rmcr_pkg::IDX_DRV_CHG: begin
        rd_byte = {6'h00, drv_chg_q};
      end
      rmcr_pkg::IDX_FLP_RATE: begin
        rd_byte = rate_q;
      end
      rmcr_pkg::IDX_SER1_FCR: begin
        rd_byte = ser1_q;
      end
      rmcr_pkg::IDX_SER2_FCR: begin
        rd_byte = ser2_q;
      end
      rmcr_pkg::IDX_KILL: begin
        rd_byte = kill_q & rmcr_pkg::KILL_MASK;
      end
      rmcr_pkg::IDX_PIN_CFG: begin
        rd_byte = pin_cfg_q & rmcr_pkg::PIN_CFG_MASK;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read data is loaded in the wait cycle and stands in the answer.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // Flag update: hardware clears, software sets, and the set wins.
  always_comb begin
    drv_chg_d = drv_chg_q;
    // Step or select low clears the flag of that drive.
    if (!pin_f_q[rmcr_pkg::P_STEP] || !pin_f_q[rmcr_pkg::P_DS0]) begin
      drv_chg_d[0] = 1'b0;
    end
    if (!pin_f_q[rmcr_pkg::P_STEP] || !pin_f_q[rmcr_pkg::P_DS1]) begin
      drv_chg_d[1] = 1'b0;
    end
    // Ones written set; zeros written leave the flag alone.
    if (wr_go && idx == rmcr_pkg::IDX_DRV_CHG) begin
      drv_chg_d = drv_chg_d | avs_writedata[1:0];
    end
  end

  // Forced disk-change flags, main-supply reset value.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_chg_q <= rmcr_pkg::RST_DRV_CHG;
    end else begin
      drv_chg_q <= drv_chg_d;
    end
  end

  // Floppy rate shadow follows the write-only register.
  // Bus writes to this offset are dropped on purpose.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_q <= rmcr_pkg::RST_SHADOW;
    end else if (rate_wr) begin
      rate_q <= rate_wdata;
    end
  end

  // Serial 1 FIFO control shadow.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser1_q <= rmcr_pkg::RST_SHADOW;
    end else if (ser1_fcr_wr) begin
      ser1_q <= ser1_fcr_wdata;
    end
  end

  // Serial 2 FIFO control shadow, same layout.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser2_q <= rmcr_pkg::RST_SHADOW;
    end else if (ser2_fcr_wr) begin
      ser2_q <= ser2_fcr_wdata;
    end
  end

  // The lock holds while the field is armed and the pin is high.
  assign kill_locked = (lock_field == rmcr_pkg::LOCK_ARMED)
                       && pin_f_q[rmcr_pkg::P_LOCK];

  // Kill switch; a locked write is dropped without an error.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kill_q <= rmcr_pkg::RST_KILL;
    end else if (wr_go && idx == rmcr_pkg::IDX_KILL && !kill_locked) begin
      kill_q <= wr_mask(avs_writedata[7:0], rmcr_pkg::KILL_MASK);
    end
  end

  // Pin configuration; reserved bits never store.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_cfg_q <= rmcr_pkg::RST_PIN_CFG;
    end else if (wr_go && idx == rmcr_pkg::IDX_PIN_CFG) begin
      pin_cfg_q <= wr_mask(avs_writedata[7:0], rmcr_pkg::PIN_CFG_MASK);
    end
  end

  // Effective enables: a set kill bit overrides the activate bit.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      floppy_enable <= 1'b0;
      midi_enable <= 1'b0;
      serial2_enable <= 1'b0;
      serial1_enable <= 1'b0;
      parallel_enable <= 1'b0;
    end else begin
      floppy_enable <= floppy_activate & ~kill_q[rmcr_pkg::KILL_FLOPPY];
      midi_enable <= midi_activate & ~kill_q[rmcr_pkg::KILL_MIDI];
      serial2_enable <= serial2_activate & ~kill_q[rmcr_pkg::KILL_SER2];
      serial1_enable <= serial1_activate & ~kill_q[rmcr_pkg::KILL_SER1];
      parallel_enable <= parallel_activate & ~kill_q[rmcr_pkg::KILL_PAR];
    end
  end

  // Disk-changed status, the logic equation taken literally on the
  // active-low lines, so a select line that reads high gates its flag.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      disk_changed_status <= 1'b1;
    end else begin
      disk_changed_status <= (pin_f_q[rmcr_pkg::P_DS0] & drv_chg_q[0])
                             | (pin_f_q[rmcr_pkg::P_DS1] & drv_chg_q[1])
                             | pin_f_q[rmcr_pkg::P_DISK_CHANGED_STATUS];
    end
  end

  // Write-protect to the floppy core; kill bit 0 overrides all.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_protect_core_n <= 1'b1;
    end else begin
      write_protect_core_n <= (pin_f_q[rmcr_pkg::P_DS0] & force_write_protect)
                              | (pin_f_q[rmcr_pkg::P_DS1] & force_write_protect)
                              | pin_f_q[rmcr_pkg::P_WRTPRT]
                              | kill_q[rmcr_pkg::KILL_WP];
    end
  end

  // Output level after the polarity bit.
  assign pin_val = gpio_out_value ^ pin_cfg_q[rmcr_pkg::PIN_INVERT];

  // Pin driver. In joystick mode or as an input the pin is released.
  // Open drain only pulls low, so a high needs an outside pull-up.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stick1_button1_pin_o <= 1'b0;
      stick1_button1_pin_oe <= 1'b0;
    end else if (pin_cfg_q[rmcr_pkg::PIN_ALT]
                 || pin_cfg_q[rmcr_pkg::PIN_DIR_IN]) begin
      stick1_button1_pin_o <= 1'b0;
      stick1_button1_pin_oe <= 1'b0;
    end else if (pin_cfg_q[rmcr_pkg::PIN_OPEN_DRAIN]) begin
      stick1_button1_pin_o <= 1'b0;
      stick1_button1_pin_oe <= ~pin_val;
    end else begin
      stick1_button1_pin_o <= pin_val;
      stick1_button1_pin_oe <= 1'b1;
    end
  end

  // Input side: the joystick sees the filtered level as is, the GPIO the
  // polarity-corrected level; the unused one reads zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpio_in_value <= 1'b0;
      stick1_button1 <= 1'b0;
    end else if (pin_cfg_q[rmcr_pkg::PIN_ALT]) begin
      gpio_in_value <= 1'b0;
      stick1_button1 <= pin_f_q[rmcr_pkg::P_STICK];
    end else begin
      gpio_in_value <= pin_f_q[rmcr_pkg::P_STICK]
                       ^ pin_cfg_q[rmcr_pkg::PIN_INVERT];
      stick1_button1 <= 1'b0;
    end
  end

  // Reads have no side effect anywhere in this slice, so a master
  // that retries a read after a timeout sees the same byte again.
  // Writes, in contrast, act only in the answer cycle, exactly once.

endmodule : rmcr_top

`default_nettype wire

//--- testbench/rmcr_properties.sv
`timescale 1ns/1ns
`default_nettype none

// Watches the bus answer, reserved read bits and the pin-driven outputs.
module rmcr_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic disk_changed_pin_n,
  input wire logic write_protect_line_n,
  input wire logic floppy_activate,
  input wire logic floppy_enable,
  input wire logic disk_changed_status,
  input wire logic write_protect_core_n
);
  // One clock domain, so one clocking and one reset serve every check.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // The slave always inserts exactly one wait state.
  AST_BUS_ANSWER: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("waitrequest late");
  AST_BUS_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_BUS_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest low without a request");
  // Reserved bits of a register read back as zero.
  AST_DRV_RSVD: assert property ($rose(avs_read) && avs_address[7:2] == 6'h1e
    |=> avs_readdata[31:2] == 30'h0) else $error("force flag spare bits set");
  AST_KILL_RSVD: assert property ($rose(avs_read) && avs_address[7:2] == 6'h22
    |=> avs_readdata[2:1] == 2'h0) else $error("kill spare bits set");
  AST_PIN_RSVD: assert property ($rose(avs_read) && avs_address[7:2] == 6'h23
    |=> avs_readdata[6:3] == 4'h0) else $error("pin cfg spare bits set");
  // A quiet pin high long enough must reach the core, whatever the flags.
  AST_DISK_CHANGED_STATUS_PIN: assert property (disk_changed_pin_n [*8] |-> disk_changed_status)
    else $error("disk changed status low with pin high");
  AST_WP_PIN: assert property (write_protect_line_n [*8] |-> write_protect_core_n)
    else $error("write protect low with pin high");
  // A function without its activate bit stays off.
  AST_FLOPPY_OFF: assert property (!floppy_activate |=> !floppy_enable)
    else $error("floppy enabled while not activated");
endmodule : rmcr_properties

bind rmcr_top rmcr_properties chk (.*);

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end

// Drives every input of the block directly; no far-side model is needed.
module testbench;
  // Inputs start at their idle levels: active-low pins rest high.
  logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00, rate_wdata = 8'h00, ser1_fcr_wdata = 8'h00;
  logic [7:0] ser2_fcr_wdata = 8'h00, rd;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [1:0] lock_field = 2'b00;
  logic head_step_pulse_n = 1'b1, drive_select_zero_n = 1'b1, drive_select_one_n = 1'b1;
  logic disk_changed_pin_n = 1'b1, write_protect_line_n = 1'b1, lock_control_pin = 1'b0;
  logic force_write_protect = 1'b0, rate_wr = 1'b0, ser1_fcr_wr = 1'b0, ser2_fcr_wr = 1'b0;
  logic floppy_activate = 1'b1, midi_activate = 1'b1, serial2_activate = 1'b1;
  logic serial1_activate = 1'b1, parallel_activate = 1'b1, gpio_out_value = 1'b0;
  logic stick1_button1_pin_i = 1'b0;
  logic avs_waitrequest, floppy_enable, midi_enable, serial2_enable, serial1_enable;
  logic parallel_enable, disk_changed_status, write_protect_core_n, stick1_button1_pin_o;
  logic stick1_button1_pin_oe, gpio_in_value, stick1_button1;
  int fails = 0;
  int compares = 0;
  // Enables gathered in kill switch bit order 7:3.
  wire [4:0] en_vec = {parallel_enable, serial1_enable, serial2_enable, midi_enable,
    floppy_enable};

  rmcr_top uut (.*);

  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end

  // Waits a number of rising edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // One Avalon transfer; held until waitrequest is seen low, then one idle cycle.
  // The master waits out any latency: only the watchdog ends a wait that never ends.
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Reads a register and compares its low byte.
  task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK("register", e, rd)
  endtask : rdchk

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Reset values of the whole slice, plus an unmapped index reading zero.
  task automatic t_regs();
    logic [7:0] e [6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    for (int i = 0; i < 6; i++) begin
      rdchk(6'h1e + 6'(i), e[i]);
    end
    rdchk(6'h1d, 8'h00);
  endtask : t_regs

  // Force flags: set by ones only, cleared by select or step, seen on status.
  task automatic t_drive();
    bus(1'b1, 6'h1e, 8'h00);
    rdchk(6'h1e, 8'h01);
    bus(1'b1, 6'h1e, 8'hff);
    rdchk(6'h1e, 8'h03);
    disk_changed_pin_n <= 1'b0;
    cyc(8);
    `CHK("disk_changed_status", 1'b1, disk_changed_status)
    drive_select_zero_n <= 1'b0;
    cyc(8);
    drive_select_zero_n <= 1'b1;
    rdchk(6'h1e, 8'h02);
    drive_select_one_n <= 1'b0;
    cyc(8);
    `CHK("disk_changed_status", 1'b0, disk_changed_status)
    drive_select_one_n <= 1'b1;
    rdchk(6'h1e, 8'h00);
    bus(1'b1, 6'h1e, 8'h03);
    head_step_pulse_n <= 1'b0;
    cyc(8);
    head_step_pulse_n <= 1'b1;
    disk_changed_pin_n <= 1'b1;
    rdchk(6'h1e, 8'h00);
  endtask : t_drive

  // Shadows follow their strobes and ignore bus writes.
  task automatic t_shadow();
    rate_wr <= 1'b1;
    rate_wdata <= 8'ha5;
    ser1_fcr_wr <= 1'b1;
    ser1_fcr_wdata <= 8'h5a;
    ser2_fcr_wr <= 1'b1;
    ser2_fcr_wdata <= 8'hc3;
    cyc(1);
    rate_wr <= 1'b0;
    ser1_fcr_wr <= 1'b0;
    ser2_fcr_wr <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 6'h1f + 6'(i), 8'hff);
    end
    rdchk(6'h1f, 8'ha5);
    rdchk(6'h20, 8'h5a);
    rdchk(6'h21, 8'hc3);
  endtask : t_shadow

  // Each kill bit turns off its own function only; write protect and lock.
  task automatic t_kill();
    for (int b = 0; b < 5; b++) begin
      bus(1'b1, 6'h22, 8'h08 << b);
      cyc(2);
      `CHK("enables", ~(5'h01 << b), en_vec)
    end
    bus(1'b1, 6'h22, 8'hff);
    rdchk(6'h22, 8'hf9);
    `CHK("enables", 5'h00, en_vec)
    bus(1'b1, 6'h22, 8'h00);
    floppy_activate <= 1'b0;
    parallel_activate <= 1'b0;
    write_protect_line_n <= 1'b0;
    cyc(8);
    `CHK("enables", 5'h0e, en_vec)
    `CHK("wp", 1'b0, write_protect_core_n)
    // The forced bit, gated by an idle (high) select line, lifts the line.
    force_write_protect <= 1'b1;
    cyc(2);
    `CHK("wp_force", 1'b1, write_protect_core_n)
    force_write_protect <= 1'b0;
    bus(1'b1, 6'h22, 8'h01);
    cyc(2);
    `CHK("wp", 1'b1, write_protect_core_n)
    floppy_activate <= 1'b1;
    parallel_activate <= 1'b1;
    write_protect_line_n <= 1'b1;
    lock_field <= 2'b01;
    lock_control_pin <= 1'b1;
    cyc(8);
    bus(1'b1, 6'h22, 8'h08);
    rdchk(6'h22, 8'h01);
    lock_control_pin <= 1'b0;
    cyc(8);
    bus(1'b1, 6'h22, 8'h08);
    rdchk(6'h22, 8'h08);
    lock_field <= 2'b00;
  endtask : t_kill

  // Pin direction, polarity, alternate use and output type.
  task automatic t_pin();
    bus(1'b1, 6'h23, 8'hfe);
    rdchk(6'h23, 8'h86);
    gpio_out_value <= 1'b1;
    bus(1'b1, 6'h23, 8'h00);
    cyc(3);
    `CHK("pin_o", 1'b1, stick1_button1_pin_o)
    `CHK("pin_oe", 1'b1, stick1_button1_pin_oe)
    bus(1'b1, 6'h23, 8'h82);
    cyc(3);
    `CHK("pin_o", 1'b0, stick1_button1_pin_o)
    // Inverted high becomes a low, which open drain actively pulls.
    `CHK("pin_oe", 1'b1, stick1_button1_pin_oe)
    bus(1'b1, 6'h23, 8'h80);
    cyc(3);
    `CHK("pin_oe", 1'b0, stick1_button1_pin_oe)
    bus(1'b1, 6'h23, 8'h04);
    stick1_button1_pin_i <= 1'b1;
    cyc(8);
    `CHK("pin_oe", 1'b0, stick1_button1_pin_oe)
    `CHK("button", 1'b1, stick1_button1)
    bus(1'b1, 6'h23, 8'h03);
    cyc(3);
    `CHK("gpio_in", 1'b0, gpio_in_value)
    // A write without the low byte lane must leave the register alone.
    avs_byteenable <= 4'he;
    bus(1'b1, 6'h23, 8'h00);
    avs_byteenable <= 4'h1;
    rdchk(6'h23, 8'h03);
  endtask : t_pin

  // Main sequence, with a second reset in mid-run.
  initial begin
    cyc(3);
    nrst <= 1'b1;
    cyc(1);
    t_regs();
    t_drive();
    t_shadow();
    t_kill();
    t_pin();
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    cyc(1);
    t_regs();
    end_of_test();
  end

  // The run needs well under 2000 cycles, so this only catches a hang.
  initial begin
    cyc(20000);
    fails++;
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
